// ==== common/iosw_pkg.sv ====
package iosw_pkg;

   // ***************************************************************
   // register map and field layout
   // ***************************************************************
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_IFS_LSB = 3;
   localparam int STAT_HF_READY = 0;
   localparam int STAT_HF_STABLE = 1;
   localparam int STAT_LF_READY = 2;
   localparam int STAT_BUSY = 3;
   localparam int STAT_SRC_LSB = 4;
   localparam int STAT_PIN = 6;

   // ***************************************************************
   // reset values and configuration codes
   // ***************************************************************
   localparam logic [3:0] IFS_RESET = 4'h7;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [1:0] SEL_SECONDARY = 2'h1;
   localparam logic [2:0] MODE_INTERNAL = 3'h4;
   localparam logic [2:0] MODE_EXT_RC = 3'h3;
   localparam logic [2:0] IFS_LF_TOP = 3'h0;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_FREQ_MHZ = 200;
   localparam int HF_START_NS = 2000;
   localparam int HF_STABLE_NS = 1000;
   localparam int LF_START_NS = 5000;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] HF_START_CNT =
      CNT_W'((HF_START_NS * CLK_FREQ_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] HF_STABLE_END =
      CNT_W'((HF_START_NS + HF_STABLE_NS) * CLK_FREQ_MHZ / 1000);
   localparam logic [CNT_W-1:0] LF_START_CNT =
      CNT_W'((LF_START_NS * CLK_FREQ_MHZ + 999) / 1000);
   localparam int DIV_W = 9;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {SRC_EXT, SRC_SEC, SRC_HF, SRC_LF} iosw_src_type;
   typedef enum logic [1:0] {SW_RUN, SW_START, SW_FALL, SW_HOLD} iosw_sw_type;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } iosw_avs_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } iosw_avs_rsp_type;

   typedef struct packed {
      logic [2:0] osc_mode_config;
      logic clock_output_enable_cfg;
      logic watchdog_enable;
      logic clk_monitor_enable;
      logic powerup_timer_enable;
   } iosw_cfg_type;

   typedef struct packed {
      logic hf;
      logic lf;
      logic sec;
      logic ext;
   } iosw_smp_type;

   typedef struct packed {
      logic hf_osc_enable;
      logic lf_osc_enable;
      logic aux_osc_enable;
      logic lf_periph_clk;
   } iosw_osc_ctl_type;

   typedef struct packed {
      logic osc_in_gpio_release;
      logic osc_out_pin_o;
      logic osc_out_pin_oe;
   } iosw_pin_type;

   // postscaler shift per select code; 000x takes the low-frequency source
   function automatic logic [3:0] iosw_div_shift(input logic [3:0] code);
      case (code)
         4'hF: iosw_div_shift = 4'h0;
         4'hE: iosw_div_shift = 4'h1;
         4'hD: iosw_div_shift = 4'h2;
         4'hC: iosw_div_shift = 4'h3;
         4'hB: iosw_div_shift = 4'h4;
         4'hA: iosw_div_shift = 4'h5;
         4'h9: iosw_div_shift = 4'h6;
         4'h8: iosw_div_shift = 4'h7;
         4'h7: iosw_div_shift = 4'h5;
         4'h6: iosw_div_shift = 4'h6;
         4'h5: iosw_div_shift = 4'h7;
         4'h4: iosw_div_shift = 4'h8;
         default: iosw_div_shift = 4'h9;
      endcase
   endfunction

endpackage

// ==== rtl/iosw_top.sv ====
`timescale 1ns/1ps
// What this block does
// - second pin: GPIO or clock out in internal and external RC modes
// - internal mode frees first pin for GPIO
// - internal mode config makes internal default
// - select upper bit one picks internal
// - 16 MHz and 31 kHz independent sources
// - HF enable: HF code and internal selected
// - HF ready flag while HF runs
// - HF stable flag within final frequency
// - LF enable: code 000x and internal selected, or peripheral need
// - LF also clocks timers and monitor
// - LF ready flag while LF runs
// - select code picks postscaled or LF
// - frequency select resets to 0111
// - duplicate codes, same source switches faster
// - start new oscillator, await current fall
// - hold low to new rise, then update
// - same source switch skips start delay
// - status shows both oscillators live state
// - aux oscillator covers HF power-up
// - clock select 00/01/1x, reset cleared
// - LF start about 5 us, HF about 2 us
module iosw_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register bus
   input wire iosw_pkg::iosw_avs_req_type avs_req,
   output iosw_pkg::iosw_avs_rsp_type avs_rsp,
   // configuration words and peripheral demands
   input wire iosw_pkg::iosw_cfg_type cfg,
   // oscillator and clock inputs
   input wire iosw_pkg::iosw_smp_type osc_in,
   // second oscillator pin in gpio use
   input wire logic gpio_out_o,
   input wire logic gpio_out_oe,
   input wire logic osc_out_pin_i,
   // oscillator control and system clock
   output iosw_pkg::iosw_osc_ctl_type osc_ctl,
   output iosw_pkg::iosw_pin_type pins,
   output logic sys_clk_out
);
   import iosw_pkg::*;

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      iosw_avs_rsp_type rsp;
      logic [3:0] ifs;
      logic [1:0] clk_sel;
      logic boot;
      iosw_src_type act_src;
      logic [3:0] act_ifs;
      iosw_src_type tgt_src;
      logic [3:0] tgt_ifs;
      iosw_sw_type sw;
      iosw_smp_type smp;
      logic pin_smp;
      logic [DIV_W-1:0] div_cnt;
      logic cur_prev;
      logic new_prev;
      logic [CNT_W-1:0] hf_cnt;
      logic hf_ready;
      logic hf_stable;
      logic [CNT_W-1:0] lf_cnt;
      logic lf_ready;
      logic sys_clk;
      iosw_osc_ctl_type osc;
      iosw_pin_type pins;
   } iosw_state_type;

   iosw_state_type s_reg;
   iosw_state_type s_next;

   logic tgt_int;
   iosw_src_type tgt_src;
   logic cur_lvl;
   logic new_lvl;
   logic [31:0] rd_data;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic src_level(input iosw_src_type src, input logic [3:0] ifs,
                                      input iosw_smp_type smp,
                                      input logic [DIV_W-1:0] div);
      logic [3:0] sh;
      sh = iosw_div_shift(ifs);
      case (src)
         SRC_HF: src_level = (sh == 4'h0) ? smp.hf : div[sh-4'h1];
         SRC_LF: src_level = smp.lf;
         SRC_SEC: src_level = smp.sec;
         default: src_level = smp.ext;
      endcase
   endfunction

   function automatic logic src_ready(input iosw_src_type src, input logic hf_rdy,
                                      input logic lf_rdy);
      case (src)
         SRC_HF: src_ready = hf_rdy;
         SRC_LF: src_ready = lf_rdy;
         default: src_ready = 1'b1;
      endcase
   endfunction

   // ***************************************************************
   // source selection
   // ***************************************************************
   assign tgt_int = s_reg.clk_sel[1] ||
      (s_reg.clk_sel == SEL_RESET && cfg.osc_mode_config == MODE_INTERNAL);
   always_comb begin
      if (tgt_int) begin
         tgt_src = (s_reg.ifs[3:1] == IFS_LF_TOP) ? SRC_LF : SRC_HF;
      end else if (s_reg.clk_sel == SEL_SECONDARY) begin
         tgt_src = SRC_SEC;
      end else begin
         tgt_src = SRC_EXT;
      end
   end

   assign cur_lvl = src_level(s_reg.act_src, s_reg.act_ifs, s_reg.smp, s_reg.div_cnt);
   assign new_lvl = src_level(s_reg.tgt_src, s_reg.tgt_ifs, s_reg.smp, s_reg.div_cnt);

   // ***************************************************************
   // register read mux
   // ***************************************************************
   always_comb begin
      rd_data = 32'h0000_0000;
      if (avs_req.address == OFS_CTRL) begin
         rd_data[CTRL_SEL_LSB +: 2] = s_reg.clk_sel;
         rd_data[CTRL_IFS_LSB +: 4] = s_reg.ifs;
      end else if (avs_req.address == OFS_STAT) begin
         rd_data[STAT_HF_READY] = s_reg.hf_ready;
         rd_data[STAT_HF_STABLE] = s_reg.hf_stable;
         rd_data[STAT_LF_READY] = s_reg.lf_ready;
         rd_data[STAT_BUSY] = (s_reg.sw != SW_RUN);
         rd_data[STAT_SRC_LSB +: 2] = s_reg.act_src;
         rd_data[STAT_PIN] = s_reg.pin_smp;
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      s_next = s_reg;

      // bus slave: one wait cycle, then a single-cycle answer
      s_next.rsp.waitrequest = 1'b1;
      if ((avs_req.read || avs_req.write) && s_reg.rsp.waitrequest) begin
         s_next.rsp.waitrequest = 1'b0;
         s_next.rsp.readdata = rd_data;
      end
      if (avs_req.write && !s_reg.rsp.waitrequest && avs_req.address == OFS_CTRL) begin
         s_next.clk_sel = avs_req.writedata[CTRL_SEL_LSB +: 2];
         s_next.ifs = avs_req.writedata[CTRL_IFS_LSB +: 4];
      end

      // input sampling; the low-frequency clock is forwarded to timers
      s_next.smp = osc_in;
      s_next.pin_smp = osc_out_pin_i;
      s_next.osc.lf_periph_clk = s_reg.smp.lf;
      if (osc_in.hf && !s_reg.smp.hf) begin
         s_next.div_cnt = s_reg.div_cnt + 1'b1;
      end
      s_next.cur_prev = cur_lvl;
      s_next.new_prev = new_lvl;

      // oscillator enables; the active and pending sources stay powered
      s_next.osc.hf_osc_enable =
         (s_reg.ifs[3:1] != IFS_LF_TOP &&
          (cfg.osc_mode_config == MODE_INTERNAL || s_reg.clk_sel[1])) ||
         s_reg.act_src == SRC_HF ||
         (s_reg.sw != SW_RUN && s_reg.tgt_src == SRC_HF);
      s_next.osc.lf_osc_enable =
         (s_reg.ifs[3:1] == IFS_LF_TOP && s_reg.clk_sel[1]) ||
         cfg.watchdog_enable || cfg.clk_monitor_enable || cfg.powerup_timer_enable ||
         s_reg.act_src == SRC_LF ||
         (s_reg.sw != SW_RUN && s_reg.tgt_src == SRC_LF);
      s_next.osc.aux_osc_enable = s_reg.osc.hf_osc_enable && !s_reg.hf_ready;

      // high-frequency start-up and settling
      if (!s_reg.osc.hf_osc_enable) begin
         s_next.hf_cnt = '0;
         s_next.hf_ready = 1'b0;
         s_next.hf_stable = 1'b0;
      end else begin
         if (s_reg.hf_cnt != HF_STABLE_END) begin
            s_next.hf_cnt = s_reg.hf_cnt + 1'b1;
         end
         s_next.hf_ready = (s_reg.hf_cnt >= HF_START_CNT);
         s_next.hf_stable = (s_reg.hf_cnt >= HF_STABLE_END);
      end

      // low-frequency start-up; already running when a timer holds it on
      if (!s_reg.osc.lf_osc_enable) begin
         s_next.lf_cnt = '0;
         s_next.lf_ready = 1'b0;
      end else begin
         if (s_reg.lf_cnt != LF_START_CNT) begin
            s_next.lf_cnt = s_reg.lf_cnt + 1'b1;
         end
         s_next.lf_ready = (s_reg.lf_cnt >= LF_START_CNT);
      end

      // glitch-free switch; a stopped current clock stalls it in SW_FALL
      case (s_reg.sw)
         SW_RUN: begin
            if (s_reg.boot) begin
               s_next.act_src = tgt_src;
               s_next.act_ifs = s_reg.ifs;
               s_next.boot = 1'b0;
            end else if (tgt_src != s_reg.act_src ||
                         (tgt_int && s_reg.ifs != s_reg.act_ifs)) begin
               s_next.tgt_src = tgt_src;
               s_next.tgt_ifs = s_reg.ifs;
               s_next.sw = SW_START;
            end
         end
         SW_START: begin
            if (src_ready(s_reg.tgt_src, s_reg.hf_ready, s_reg.lf_ready)) begin
               s_next.sw = SW_FALL;
            end
         end
         SW_FALL: begin
            if (s_reg.cur_prev && !cur_lvl) begin
               s_next.sw = SW_HOLD;
            end
         end
         SW_HOLD: begin
            if (!s_reg.new_prev && new_lvl) begin
               s_next.act_src = s_reg.tgt_src;
               s_next.act_ifs = s_reg.tgt_ifs;
               s_next.sw = SW_RUN;
            end
         end
         default: begin
            s_next.sw = SW_RUN;
         end
      endcase

      s_next.sys_clk = (s_reg.sw != SW_HOLD) && cur_lvl &&
         src_ready(s_reg.act_src, s_reg.hf_ready, s_reg.lf_ready);

      // oscillator pins
      s_next.pins.osc_in_gpio_release = (cfg.osc_mode_config == MODE_INTERNAL);
      if (cfg.osc_mode_config == MODE_INTERNAL || cfg.osc_mode_config == MODE_EXT_RC) begin
         if (cfg.clock_output_enable_cfg) begin
            s_next.pins.osc_out_pin_o = s_reg.sys_clk;
            s_next.pins.osc_out_pin_oe = 1'b1;
         end else begin
            s_next.pins.osc_out_pin_o = gpio_out_o;
            s_next.pins.osc_out_pin_oe = gpio_out_oe;
         end
      end else begin
         s_next.pins.osc_out_pin_o = 1'b0;
         s_next.pins.osc_out_pin_oe = 1'b0;
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.ifs <= IFS_RESET;
         s_reg.clk_sel <= SEL_RESET;
         s_reg.rsp.waitrequest <= 1'b1;
         s_reg.boot <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign avs_rsp = s_reg.rsp;
   assign osc_ctl = s_reg.osc;
   assign pins = s_reg.pins;
   assign sys_clk_out = s_reg.sys_clk;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence seq_start_done;
      s_reg.sw == SW_START && s_reg.tgt_src == SRC_HF && s_reg.hf_ready;
   endsequence

   sequence seq_hold_exit;
      s_reg.sw == SW_HOLD ##1 s_reg.sw == SW_RUN;
   endsequence

   sequence seq_lf_warm;
      s_reg.sw == SW_START && s_reg.tgt_src == SRC_LF && s_reg.lf_ready;
   endsequence

   a_reset_values: assert property ($fell(sys_rst) |->
      s_reg.ifs == IFS_RESET && s_reg.clk_sel == SEL_RESET)
      else $error("select fields wrong after reset");

   a_hf_enable: assert property (
      (s_reg.ifs[3:1] != IFS_LF_TOP && s_reg.clk_sel[1]) |=> s_reg.osc.hf_osc_enable)
      else $error("hf oscillator not enabled");

   a_lf_enable: assert property (
      ((s_reg.ifs[3:1] == IFS_LF_TOP && s_reg.clk_sel[1]) || cfg.watchdog_enable ||
       cfg.clk_monitor_enable || cfg.powerup_timer_enable)
      |=> s_reg.osc.lf_osc_enable)
      else $error("lf oscillator not enabled");

   a_hf_startup_delay: assert property (
      $rose(s_reg.osc.hf_osc_enable) |-> !s_reg.hf_ready [*8])
      else $error("hf ready too soon");

   a_stable_after_ready: assert property (s_reg.hf_stable |-> s_reg.hf_ready)
      else $error("stable without ready");

   a_hold_clock_low: assert property (s_reg.sw == SW_HOLD |-> !s_reg.sys_clk)
      else $error("system clock not held low");

   a_switch_update: assert property (seq_hold_exit |->
      s_reg.act_src == $past(s_reg.tgt_src) && s_reg.act_ifs == $past(s_reg.tgt_ifs))
      else $error("active source not updated");

   a_same_src_fast: assert property (seq_start_done |=> s_reg.sw == SW_FALL)
      else $error("same source switch delayed");

   a_aux_osc: assert property (
      $rose(s_reg.osc.hf_osc_enable) |=> s_reg.osc.aux_osc_enable)
      else $error("aux oscillator not started");

   a_gpio_release: assert property (
      !$past(sys_rst) && $past(cfg.osc_mode_config) == MODE_INTERNAL |->
      s_reg.pins.osc_in_gpio_release)
      else $error("first pin not released");

   a_clock_out: assert property (
      $past(!sys_rst && cfg.osc_mode_config == MODE_INTERNAL && cfg.clock_output_enable_cfg) |->
      s_reg.pins.osc_out_pin_oe && s_reg.pins.osc_out_pin_o == $past(s_reg.sys_clk))
      else $error("clock output not driven");

   a_bus_answer: assert property (
      (avs_req.read || avs_req.write) && s_reg.rsp.waitrequest |=>
      !s_reg.rsp.waitrequest ##1 s_reg.rsp.waitrequest)
      else $error("bus answer timing wrong");

   a_boot_source: assert property ($fell(sys_rst) && tgt_int |=>
      s_reg.act_src == SRC_HF || s_reg.act_src == SRC_LF)
      else $error("internal block not default after reset");

   a_hf_ready_drop: assert property (
      !s_reg.osc.hf_osc_enable |=> !s_reg.hf_ready && !s_reg.hf_stable)
      else $error("hf flags outlive the oscillator");

   a_lf_ready_drop: assert property (!s_reg.osc.lf_osc_enable |=> !s_reg.lf_ready)
      else $error("lf flag outlives the oscillator");

   a_periph_clock: assert property (
      s_reg.osc.lf_periph_clk == $past(s_reg.smp.lf))
      else $error("peripheral clock not forwarded");

   a_hf_shutdown: assert property (
      s_reg.ifs[3:1] == IFS_LF_TOP && s_reg.act_src != SRC_HF && s_reg.sw == SW_RUN
      |=> !s_reg.osc.hf_osc_enable)
      else $error("hf oscillator left running");

   a_lf_shutdown: assert property (
      s_reg.ifs[3:1] != IFS_LF_TOP && s_reg.act_src != SRC_LF && s_reg.sw == SW_RUN &&
      !cfg.watchdog_enable && !cfg.clk_monitor_enable && !cfg.powerup_timer_enable
      |=> !s_reg.osc.lf_osc_enable)
      else $error("lf oscillator left running");

   a_fall_wait: assert property (
      s_reg.sw == SW_FALL && !(s_reg.cur_prev && !cur_lvl) |=> s_reg.sw == SW_FALL)
      else $error("switch left fall wait early");

   a_hold_wait: assert property (
      s_reg.sw == SW_HOLD && !(!s_reg.new_prev && new_lvl) |=> s_reg.sw == SW_HOLD)
      else $error("switch left hold early");

   a_lf_warm_fast: assert property (seq_lf_warm |=> s_reg.sw == SW_FALL)
      else $error("warm lf switch delayed");

endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
   import iosw_pkg::*;
   // ***********************************************
   // stimulus and design
   // ***********************************************
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   iosw_avs_req_type avs_req = '0;
   iosw_avs_rsp_type avs_rsp;
   iosw_cfg_type cfg = '{MODE_INTERNAL, 1'b0, 1'b0, 1'b0, 1'b0};
   iosw_smp_type osc_in = '0;
   logic gpio_out_o = 1'b1;
   logic gpio_out_oe = 1'b1;
   logic osc_out_pin_i = 1'b0;
   iosw_osc_ctl_type osc_ctl;
   iosw_pin_type pins;
   logic sys_clk_out;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int t0;
   int c[4];
   logic [31:0] rd;
   logic [3:0] codes[5] = '{4'hF, 4'hE, 4'hD, 4'hB, 4'h7};
   int shf[5] = '{0, 1, 2, 4, 5};

   iosw_top iosw_top_i (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .avs_req(avs_req),
      .avs_rsp(avs_rsp),
      .cfg(cfg),
      .osc_in(osc_in),
      .gpio_out_o(gpio_out_o),
      .gpio_out_oe(gpio_out_oe),
      .osc_out_pin_i(osc_out_pin_i),
      .osc_ctl(osc_ctl),
      .pins(pins),
      .sys_clk_out(sys_clk_out)
   );

   always #2.5 clk_sys = ~clk_sys;

   // oscillators only swing while enabled, so a missing enable stalls the switch
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      osc_in.hf <= osc_ctl.hf_osc_enable ? ~osc_in.hf : 1'b0;
      osc_in.lf <= osc_ctl.lf_osc_enable ? cyc[3] : 1'b0;
      osc_in.ext <= (cyc % 6) < 3;
      osc_in.sec <= (cyc % 10) < 5;
   end

   // ***********************************************
   // shared tasks
   // ***********************************************
   task automatic stop_test;
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic near(input string what, input int exp, input int got);
      n_checks++;
      if (got < exp - 1 || got > exp + 1) begin
         failures++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_req <= '{address: addr, read: !wr, write: wr, writedata: wdata};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_rsp.waitrequest !== 1'b0 && n < 200);
      if (n >= 200) begin
         failures++;
         $display("ERROR bus answer expected waitrequest low seen none");
         stop_test;
      end
      rd = avs_rsp.readdata;
      avs_req <= '0;
   endtask

   // poll status until a bit reaches a level, bounded
   task automatic poll(input int bit_no, input logic lvl, input int max_reads);
      int n;
      n = 0;
      do begin
         bus(1'b0, OFS_STAT, 32'h0);
         n++;
      end while (rd[bit_no] !== lvl && n < max_reads);
      if (n >= max_reads) begin
         failures++;
         $display("ERROR status bit %0d expected %b seen timeout", bit_no, lvl);
         stop_test;
      end
   endtask

   // select a source and wait for the switch to finish; rd holds final status
   task automatic switch_to(input logic [3:0] ifs, input logic [1:0] sel);
      t0 = cyc;
      bus(1'b1, OFS_CTRL, 32'({ifs, 1'b0, sel}));
      repeat (2) @(posedge clk_sys);
      poll(STAT_BUSY, 1'b0, 1000);
   endtask

   // c[3] system clock, c[2] second pin, c[1] peripheral clock, c[0] low osc
   task automatic count_rises(input int cycles);
      logic [3:0] now;
      logic [3:0] prev;
      c = '{0, 0, 0, 0};
      prev = {sys_clk_out, pins.osc_out_pin_o, osc_ctl.lf_periph_clk, osc_in.lf};
      repeat (cycles) begin
         @(posedge clk_sys);
         #1;
         now = {sys_clk_out, pins.osc_out_pin_o, osc_ctl.lf_periph_clk, osc_in.lf};
         for (int k = 0; k < 4; k++)
            if (now[k] && !prev[k])
               c[k]++;
         prev = now;
      end
   endtask

   initial begin
      repeat (90000) @(posedge clk_sys);
      failures++;
      $display("ERROR run length expected end seen timeout");
      stop_test;
   end

   // ***********************************************
   // scenarios
   // ***********************************************
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      bus(1'b0, OFS_CTRL, 32'h0);
      check("ctrl reset", 32'h38, rd);
      bus(1'b0, OFS_STAT, 32'h0);
      check("source after reset", 32'h2, 32'(rd[5:4]));
      #1;
      check("hf enable", 32'h1, 32'(osc_ctl.hf_osc_enable));
      check("aux enable", 32'h1, 32'(osc_ctl.aux_osc_enable));
      check("lf enable idle", 32'h0, 32'(osc_ctl.lf_osc_enable));
      check("first pin free", 32'h1, 32'(pins.osc_in_gpio_release));
      check("second pin oe", 32'h1, 32'(pins.osc_out_pin_oe));
      check("second pin out", 32'h1, 32'(pins.osc_out_pin_o));
      poll(STAT_HF_READY, 1'b1, 600);
      check("stable before ready", 32'h0, 32'(rd[STAT_HF_STABLE]));
      #1;
      check("aux after ready", 32'h0, 32'(osc_ctl.aux_osc_enable));
      poll(STAT_HF_STABLE, 1'b1, 200);
      @(posedge clk_sys);
      cfg.clock_output_enable_cfg <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         switch_to(codes[i], 2'b10);
         check("hf source", 32'h2, 32'(rd[5:4]));
         near("same source time", 0, ((cyc - t0) < 400) ? 0 : 9);
         count_rises(256);
         near("sys clk rises", 128 >> shf[i], c[3]);
         near("clock out rises", 128 >> shf[i], c[2]);
      end
      t0 = cyc;
      bus(1'b1, OFS_CTRL, 32'h2);
      repeat (4) @(posedge clk_sys);
      #1;
      check("lf enable", 32'h1, 32'(osc_ctl.lf_osc_enable));
      repeat (2) @(posedge clk_sys);
      poll(STAT_BUSY, 1'b0, 1000);
      check("lf source", 32'h3, 32'(rd[5:4]));
      check("lf ready", 32'h1, 32'(rd[STAT_LF_READY]));
      near("lf start", 0, ((cyc - t0) >= 1000) ? 0 : 9);
      repeat (20) @(posedge clk_sys);
      #1;
      check("hf shut down", 32'h0, 32'(osc_ctl.hf_osc_enable));
      bus(1'b0, OFS_STAT, 32'h0);
      check("hf ready off", 32'h0, 32'(rd[STAT_HF_READY]));
      count_rises(256);
      near("lf sys clk rises", 16, c[3]);
      switch_to(4'hF, 2'b10);
      check("back to hf", 32'h2, 32'(rd[5:4]));
      check("hf ready again", 32'h1, 32'(rd[STAT_HF_READY]));
      near("hf start", 0, ((cyc - t0) >= 400) ? 0 : 9);
      @(posedge clk_sys);
      cfg.watchdog_enable <= 1'b1;
      poll(STAT_LF_READY, 1'b1, 600);
      count_rises(64);
      near("peripheral clock", c[0], c[1]);
      check("lf swings", 32'h1, 32'(c[0] >= 3));
      switch_to(4'h0, 2'b10);
      check("lf source warm", 32'h3, 32'(rd[5:4]));
      near("warm lf switch", 0, ((cyc - t0) < 200) ? 0 : 9);
      bus(1'b0, 4'h8, 32'h0);
      check("unmapped read", 32'h0, rd);
      bus(1'b1, OFS_STAT, 32'hFFFF_FFFF);
      bus(1'b0, OFS_STAT, 32'h0);
      check("status spare bits", 32'h0, 32'(rd[31:7]));
      osc_out_pin_i <= 1'b1;
      bus(1'b0, OFS_STAT, 32'h0);
      check("pin level high", 32'h1, 32'(rd[STAT_PIN]));
      osc_out_pin_i <= 1'b0;
      bus(1'b0, OFS_STAT, 32'h0);
      check("pin level low", 32'h0, 32'(rd[STAT_PIN]));
      @(posedge clk_sys);
      cfg.osc_mode_config <= MODE_EXT_RC;
      cfg.clock_output_enable_cfg <= 1'b0;
      gpio_out_oe <= 1'b0;
      switch_to(4'hF, 2'b00);
      check("default source", 32'h0, 32'(rd[5:4]));
      #1;
      check("first pin held", 32'h0, 32'(pins.osc_in_gpio_release));
      check("gpio oe", 32'h0, 32'(pins.osc_out_pin_oe));
      switch_to(4'hF, 2'b01);
      check("secondary source", 32'h1, 32'(rd[5:4]));
      switch_to(4'hF, 2'b11);
      check("internal by 1x", 32'h2, 32'(rd[5:4]));
      cfg.watchdog_enable <= 1'b0;
      cfg.clk_monitor_enable <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      check("lf by monitor", 32'h1, 32'(osc_ctl.lf_osc_enable));
      @(posedge clk_sys);
      cfg.clk_monitor_enable <= 1'b0;
      cfg.powerup_timer_enable <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      check("lf by power-up timer", 32'h1, 32'(osc_ctl.lf_osc_enable));
      @(posedge clk_sys);
      cfg.powerup_timer_enable <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("lf idle off", 32'h0, 32'(osc_ctl.lf_osc_enable));
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      bus(1'b0, OFS_CTRL, 32'h0);
      check("ctrl second reset", 32'h38, rd);
      bus(1'b0, OFS_STAT, 32'h0);
      check("rc default source", 32'h0, 32'(rd[5:4]));
      @(posedge clk_sys);
      cfg.osc_mode_config <= MODE_INTERNAL;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      bus(1'b0, OFS_STAT, 32'h0);
      check("internal default", 32'h2, 32'(rd[5:4]));
      stop_test;
   end
endmodule
